// file: lcc_pkg.sv
/*
  Shared constants and types for the logic, clear and complement execution unit.
  Assumes a single 250 MHz core clock and an 8-bit data path.
*/
`default_nettype none
package lcc_pkg;

  // data path widths
  localparam int DATA_W      = 8;
  localparam int NIB_W       = 4;
  localparam int ADDR_W      = 7;
  localparam int PC_W        = 11;
  localparam int BIT_SEL_W   = 3;
  localparam int WDT_W       = 8;
  localparam int OP_W        = 4;

  // storage sizes
  localparam int MEM_WORDS   = 96;
  localparam int STACK_DEPTH = 4;

  // reset values and fixed byte, count and step constants
  localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST   = 11'h000;
  localparam logic [WDT_W-1:0]  WDT_ZERO = 8'h00;
  localparam logic [WDT_W-1:0]  WDT_LAST = 8'hFF;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE  = 8'h01;
  localparam logic [PC_W-1:0]   PC_STEP   = 11'h001;

  // decimal adjust figures
  localparam logic [NIB_W:0]   BCD_MAX  = 5'h09;
  localparam logic [NIB_W-1:0] BCD_FIX  = 4'h6;

  // operations of this group
  typedef enum logic [OP_W-1:0] {
    LCC_OP_AND_MEM,
    LCC_OP_AND_IMM,
    LCC_OP_AND_INTO_MEM,
    LCC_OP_CALL,
    LCC_OP_CLR_BYTE,
    LCC_OP_CLR_BIT,
    LCC_OP_WDT_CLR,
    LCC_OP_WDT_PRE1,
    LCC_OP_WDT_PRE2,
    LCC_OP_CPL,
    LCC_OP_COMPLEMENT_TO_ACCUMULATOR_OP,
    LCC_OP_DAA,
    LCC_OP_DEC,
    LCC_OP_DECREMENT_TO_ACCUMULATOR_OP
  } lcc_op_e;

endpackage : lcc_pkg
`default_nettype wire

// file: lcc_ram.sv
/*
  Data memory: one write port, one read port with registered read data.
  Assumes addresses below WORDS; higher addresses read the last value and do not write.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_ram
  import lcc_pkg::*;
#(
  parameter int WORDS = MEM_WORDS
) (
  // clock
  input  wire logic              ref_clk,
  // read port
  input  wire logic [ADDR_W-1:0] rd_addr,
  output var  logic [DATA_W-1:0] rd_data,
  // write port
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [DATA_W-1:0] wr_data
);

  logic [DATA_W-1:0] mem [WORDS];

  // storage write and registered read
  always_ff @(posedge ref_clk) begin
    if (wr_en && (int'(wr_addr) < WORDS)) begin
      mem[wr_addr] <= wr_data;
    end
    if (int'(rd_addr) < WORDS) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule : lcc_ram
`default_nettype wire

// file: lcc_stack.sv
/*
  Return address stack, push only, wrapping after DEPTH entries.
  Assumes push arrives as a one-cycle pulse from the core clock domain.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_stack
  import lcc_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
) (
  // clock and reset
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  // push side
  input  wire logic            push,
  input  wire logic [PC_W-1:0] push_data,
  // observation
  output var  logic [PC_W-1:0] top_data
);

  typedef struct packed {
    logic [DEPTH-1:0][PC_W-1:0]  slot;
    logic [$clog2(DEPTH)-1:0]    ptr;
    logic [PC_W-1:0]             top;
  } lcc_stack_s;

  lcc_stack_s st_reg;
  lcc_stack_s st_next;

  // push writes the slot and moves the pointer
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.slot[st_reg.ptr] = push_data;
      st_next.ptr              = st_reg.ptr + 1'b1;
      st_next.top              = push_data;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign top_data = st_reg.top;

endmodule : lcc_stack
`default_nettype wire

// file: lcc_exec.sv
/*
  Execution unit for the AND, call, clear, watchdog clear, complement, decimal
  adjust and decrement operations of an 8-bit core.
  Assumes all inputs come from logic on ref_clk; one operation is taken while idle.
*/
// Behaviour
// - AND memory byte into accumulator, result in accumulator.
// - AND immediate constant into accumulator, result in accumulator.
// - AND accumulator with memory byte, result back to memory.
// - Call pushes program counter plus one, then loads target address.
// - Byte clear writes zero to the addressed memory byte.
// - Bit clear zeroes only the selected bit of the memory byte.
// - Watchdog clear zeroes count and clears powerdown and timeout flags.
// - Preclear clears count and both flags only after both preclear operations ran.
// - First preclear alone only records itself; count and flags unchanged.
// - Second preclear alone only records itself; count and flags unchanged.
// - Complement in place inverts the memory byte and writes it back.
// - Complement to accumulator loads inverted byte; memory stays unchanged.
// - Low nibble above nine or half carry: add six, adjust carry inverse.
// - High nibble plus adjust carry above nine or carry: add six, set carry.
// - Decimal adjust writes memory only and changes only the carry flag.
// - Decrement in place writes memory byte minus one back.
// - Decrement to accumulator loads byte minus one; memory unchanged.
// - AND operations update zero flag only; other arithmetic flags untouched.
// - Incomplete preclear keeps timeout and powerdown flags as they were.
`timescale 1ns/100ps
`default_nettype none
module lcc_exec
  import lcc_pkg::*;
#(
  parameter int MEM_SIZE  = MEM_WORDS,
  parameter int STK_DEPTH = STACK_DEPTH
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  // operation request
  input  wire logic                 op_valid,
  input  wire logic [OP_W-1:0]      op_code,
  input  wire logic [ADDR_W-1:0]    op_addr,
  input  wire logic [DATA_W-1:0]    op_imm,
  input  wire logic [BIT_SEL_W-1:0] op_bit,
  input  wire logic [PC_W-1:0]      op_target,
  // memory preload
  input  wire logic                 load_wr_en,
  input  wire logic [ADDR_W-1:0]    load_addr,
  input  wire logic [DATA_W-1:0]    load_data,
  // watchdog events
  input  wire logic                 wdt_tick,
  input  wire logic                 halt_req,
  // operation status
  output logic                      busy,
  output logic                      done,
  output logic [DATA_W-1:0]         result_data,
  // core state
  output logic [DATA_W-1:0]         acc,
  output logic [PC_W-1:0]           pc,
  output logic [PC_W-1:0]           stack_top,
  // status flags
  output logic                      zero_flag,
  output logic                      carry_flag,
  output logic                      half_carry_flag,
  output logic                      overflow_flag,
  // watchdog state
  output logic [WDT_W-1:0]          watchdog_count,
  output logic                      timeout_flag,
  output logic                      powerdown_flag,
  output logic                      preclear_first_seen,
  output logic                      preclear_second_seen
);

  typedef enum logic {
    LCC_IDLE,
    LCC_EXEC
  } lcc_state_e;

  typedef struct packed {
    lcc_state_e           state;
    lcc_op_e              op;
    logic [ADDR_W-1:0]    addr;
    logic [DATA_W-1:0]    imm;
    logic [BIT_SEL_W-1:0] bsel;
    logic [PC_W-1:0]      target;
    logic                 busy;
    logic                 done;
    logic [DATA_W-1:0]    result;
    logic [DATA_W-1:0]    acc;
    logic [PC_W-1:0]      pc;
    logic                 z;
    logic                 c;
    logic                 ac;
    logic                 ov;
    logic [WDT_W-1:0]     wdt;
    logic                 to;
    logic                 pd;
    logic                 pre1;
    logic                 pre2;
  } lcc_exec_s;

  lcc_exec_s st_reg;
  lcc_exec_s st_next;

  // memory and stack hookup
  logic [DATA_W-1:0] mem_rd_data;
  logic [ADDR_W-1:0] mem_rd_addr;
  logic              mem_wr_en;
  logic [ADDR_W-1:0] mem_wr_addr;
  logic [DATA_W-1:0] mem_wr_data;
  logic              stk_push;
  logic              take_op;

  // zero test shared by every zero flag update
  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    is_zero = (v == BYTE_ZERO);
  endfunction : is_zero

  // decimal adjust of the accumulator; returns {carry, byte}
  function automatic logic [DATA_W:0] bcd_adjust(
    input logic [DATA_W-1:0] a,
    input logic              hc,
    input logic              cy
  );
    logic [NIB_W-1:0] lo;
    logic             adj;
    logic [NIB_W:0]   hi_sum;
    logic [NIB_W-1:0] hi;
    logic             cy_out;
    lo     = a[NIB_W-1:0];
    adj    = 1'b0;
    cy_out = cy;
    if (({1'b0, a[NIB_W-1:0]} > BCD_MAX) || hc) begin
      lo  = a[NIB_W-1:0] + BCD_FIX;
      adj = ~hc;
    end
    hi_sum = {1'b0, a[DATA_W-1:NIB_W]} + {{NIB_W{1'b0}}, adj};
    hi     = hi_sum[NIB_W-1:0];
    if ((hi_sum > BCD_MAX) || cy) begin
      hi     = hi_sum[NIB_W-1:0] + BCD_FIX;
      cy_out = 1'b1;
    end
    bcd_adjust = {cy_out, hi, lo};
  endfunction : bcd_adjust

  // operand read is issued in the cycle the operation is taken
  assign take_op     = op_valid && (st_reg.state == LCC_IDLE);
  assign mem_rd_addr = op_addr;

  // next state of the whole unit
  always_comb begin
    logic [DATA_W-1:0] m;
    logic [DATA_W-1:0] r;
    logic [DATA_W:0]   d;
    logic              wr;
    logic              clr_wd;
    logic              push;
    m      = mem_rd_data;
    r      = BYTE_ZERO;
    d      = '0;
    wr     = 1'b0;
    clr_wd = 1'b0;
    push   = 1'b0;
    st_next      = st_reg;
    st_next.done = 1'b0;

    case (st_reg.state)
      LCC_IDLE: begin
        if (take_op) begin
          st_next.state  = LCC_EXEC;
          st_next.op     = lcc_op_e'(op_code);
          st_next.addr   = op_addr;
          st_next.imm    = op_imm;
          st_next.bsel   = op_bit;
          st_next.target = op_target;
          st_next.busy   = 1'b1;
        end
      end
      LCC_EXEC: begin
        st_next.state = LCC_IDLE;
        st_next.busy  = 1'b0;
        st_next.done  = 1'b1;
        case (st_reg.op)
          LCC_OP_AND_MEM: begin
            r           = st_reg.acc & m;
            st_next.acc = r;
            st_next.z   = is_zero(r);
          end
          LCC_OP_AND_IMM: begin
            r           = st_reg.acc & st_reg.imm;
            st_next.acc = r;
            st_next.z   = is_zero(r);
          end
          LCC_OP_AND_INTO_MEM: begin
            r         = st_reg.acc & m;
            wr        = 1'b1;
            st_next.z = is_zero(r);
          end
          LCC_OP_CALL: begin
            push       = 1'b1;
            st_next.pc = st_reg.target;
          end
          LCC_OP_CLR_BYTE: begin
            r  = BYTE_ZERO;
            wr = 1'b1;
          end
          LCC_OP_CLR_BIT: begin
            r               = m;
            r[st_reg.bsel]  = 1'b0;
            wr              = 1'b1;
          end
          LCC_OP_WDT_CLR: begin
            clr_wd       = 1'b1;
            st_next.pre1 = 1'b0;
            st_next.pre2 = 1'b0;
          end
          LCC_OP_WDT_PRE1: begin
            if (st_reg.pre2) begin
              clr_wd       = 1'b1;
              st_next.pre1 = 1'b0;
              st_next.pre2 = 1'b0;
            end else begin
              st_next.pre1 = 1'b1;
            end
          end
          LCC_OP_WDT_PRE2: begin
            if (st_reg.pre1) begin
              clr_wd       = 1'b1;
              st_next.pre1 = 1'b0;
              st_next.pre2 = 1'b0;
            end else begin
              st_next.pre2 = 1'b1;
            end
          end
          LCC_OP_CPL: begin
            r         = ~m;
            wr        = 1'b1;
            st_next.z = is_zero(r);
          end
          LCC_OP_COMPLEMENT_TO_ACCUMULATOR_OP: begin
            r           = ~m;
            st_next.acc = r;
            st_next.z   = is_zero(r);
          end
          LCC_OP_DAA: begin
            d         = bcd_adjust(st_reg.acc, st_reg.ac, st_reg.c);
            r         = d[DATA_W-1:0];
            wr        = 1'b1;
            st_next.c = d[DATA_W];
          end
          LCC_OP_DEC: begin
            r         = m - BYTE_ONE;
            wr        = 1'b1;
            st_next.z = is_zero(r);
          end
          LCC_OP_DECREMENT_TO_ACCUMULATOR_OP: begin
            r           = m - BYTE_ONE;
            st_next.acc = r;
            st_next.z   = is_zero(r);
          end
          default: begin
            r = BYTE_ZERO;
          end
        endcase
        st_next.result = r;
        if (st_reg.op != LCC_OP_CALL) begin
          st_next.pc = st_reg.pc + PC_STEP;
        end
      end
      default: begin
        st_next.state = LCC_IDLE;
        st_next.busy  = 1'b0;
      end
    endcase

    // watchdog count runs on the divided tick and wraps into a timeout
    if (wdt_tick) begin
      st_next.wdt = st_reg.wdt + 1'b1;
    end
    if (clr_wd) begin
      st_next.wdt = WDT_ZERO;
      st_next.to  = 1'b0;
      st_next.pd  = 1'b0;
    end
    // a hardware set in the same cycle as a clear wins
    if (wdt_tick && (st_reg.wdt == WDT_LAST)) begin
      st_next.to = 1'b1;
    end
    if (halt_req) begin
      st_next.pd = 1'b1;
      st_next.to = 1'b0;
    end

    mem_wr_en   = 1'b0;
    mem_wr_addr = load_addr;
    mem_wr_data = load_data;
    if (wr) begin
      mem_wr_en   = 1'b1;
      mem_wr_addr = st_reg.addr;
      mem_wr_data = r;
    end else if (load_wr_en && (st_reg.state == LCC_IDLE) && !take_op) begin
      mem_wr_en   = 1'b1;                                 // preload only while idle
    end
    stk_push  = push;
  end

  // single state register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.state <= LCC_IDLE;
      st_reg.op    <= LCC_OP_AND_MEM;
      st_reg.acc   <= ACC_RST;
      st_reg.pc    <= PC_RST;
      st_reg.wdt   <= WDT_ZERO;
    end else begin
      st_reg <= st_next;
    end
  end

  // data memory with registered read
  lcc_ram #(
    .WORDS   (MEM_SIZE)
  ) u_ram (
    .ref_clk (ref_clk),
    .rd_addr (mem_rd_addr),
    .rd_data (mem_rd_data),
    .wr_en   (mem_wr_en),
    .wr_addr (mem_wr_addr),
    .wr_data (mem_wr_data)
  );

  // return stack takes the address of the next instruction
  lcc_stack #(
    .DEPTH     (STK_DEPTH)
  ) u_stack (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .push      (stk_push),
    .push_data (st_reg.pc + PC_STEP),
    .top_data  (stack_top)
  );

  // outputs straight from the state register
  assign busy                 = st_reg.busy;
  assign done                 = st_reg.done;
  assign result_data          = st_reg.result;
  assign acc                  = st_reg.acc;
  assign pc                   = st_reg.pc;
  assign zero_flag            = st_reg.z;
  assign carry_flag           = st_reg.c;
  assign half_carry_flag      = st_reg.ac;
  assign overflow_flag        = st_reg.ov;
  assign watchdog_count       = st_reg.wdt;
  assign timeout_flag         = st_reg.to;
  assign powerdown_flag       = st_reg.pd;
  assign preclear_first_seen  = st_reg.pre1;
  assign preclear_second_seen = st_reg.pre2;

endmodule : lcc_exec
`default_nettype wire

// file: lcc_exec_sva.sv
/*
  Checker for the lcc_exec execution unit: handshake timing, results and watchdog clearing.
  Assumes one clock domain; bound to every lcc_exec instance below.
*/
`timescale 1ns/100ps
`default_nettype none
module lcc_exec_sva
  import lcc_pkg::*;
(
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              nrst,
  // request side
  input wire logic              op_valid,
  input wire logic [OP_W-1:0]   op_code,
  input wire logic [DATA_W-1:0] op_imm,
  input wire logic [PC_W-1:0]   op_target,
  input wire logic              wdt_tick,
  input wire logic              halt_req,
  // results
  input wire logic              busy,
  input wire logic              done,
  input wire logic [DATA_W-1:0] result_data,
  input wire logic [DATA_W-1:0] acc,
  input wire logic [PC_W-1:0]   pc,
  input wire logic [PC_W-1:0]   stack_top,
  input wire logic              zero_flag,
  input wire logic              carry_flag,
  input wire logic              half_carry_flag,
  input wire logic              overflow_flag,
  input wire logic [WDT_W-1:0]  watchdog_count,
  input wire logic              timeout_flag,
  input wire logic              powerdown_flag,
  input wire logic              preclear_first_seen,
  input wire logic              preclear_second_seen
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // an operation is taken at this edge
  wire logic take;
  assign take = op_valid && !busy;

  // one busy cycle, then one done cycle
  busy_done_a: assert property (take |=> busy ##1 (!busy && done)) else $error("busy or done misplaced");
  and_imm_a: assert property (take && op_code == LCC_OP_AND_IMM |=> ##1 acc == ($past(acc, 2) & $past(op_imm, 2)))
    else $error("immediate and result wrong");
  and_flags_a: assert property (take && op_code inside {LCC_OP_AND_MEM, LCC_OP_AND_IMM, LCC_OP_AND_INTO_MEM}
    |=> ##1 carry_flag == $past(carry_flag, 2) && zero_flag == (result_data == BYTE_ZERO)) else $error("and flags wrong");
  no_half_ov_a: assert property (!half_carry_flag && !overflow_flag) else $error("half carry or overflow moved");
  call_push_a: assert property (take && op_code == LCC_OP_CALL |=> ##1 pc == $past(op_target, 2)
    && stack_top == $past(pc, 2) + PC_STEP) else $error("call target or push wrong");
  daa_keep_a: assert property (take && op_code == LCC_OP_DAA |=> ##1 acc == $past(acc, 2)
    && zero_flag == $past(zero_flag, 2)) else $error("decimal adjust touched accumulator");
  wdt_clear_a: assert property (take && op_code == LCC_OP_WDT_CLR |=> ##1 watchdog_count == WDT_ZERO
    && powerdown_flag == $past(halt_req) && timeout_flag == ($past(wdt_tick) && $past(watchdog_count) == WDT_LAST
    && !$past(halt_req))) else $error("watchdog clear incomplete");
  pre_single_a: assert property ((take && !wdt_tick && !halt_req
    && (op_code == LCC_OP_WDT_PRE1 && !preclear_second_seen || op_code == LCC_OP_WDT_PRE2 && !preclear_first_seen))
    ##1 (!wdt_tick && !halt_req) |=> watchdog_count == $past(watchdog_count, 2)
    && timeout_flag == $past(timeout_flag, 2) && powerdown_flag == $past(powerdown_flag, 2))
    else $error("single preclear changed watchdog");
  pre_pair_a: assert property (take && (op_code == LCC_OP_WDT_PRE2 && preclear_first_seen
    || op_code == LCC_OP_WDT_PRE1 && preclear_second_seen) |=> ##1 watchdog_count == WDT_ZERO
    && powerdown_flag == $past(halt_req) && timeout_flag == ($past(wdt_tick) && $past(watchdog_count) == WDT_LAST
    && !$past(halt_req))) else $error("preclear pair did not clear");

  // main scenarios reached
  call_c: cover property (take && op_code == LCC_OP_CALL);
  pair_c: cover property (take && op_code == LCC_OP_WDT_PRE2 && preclear_first_seen);
  daa_c: cover property (take && op_code == LCC_OP_DAA ##2 carry_flag);
endmodule : lcc_exec_sva

bind lcc_exec lcc_exec_sva u_sva (.ref_clk, .nrst, .op_valid, .op_code, .op_imm, .op_target, .wdt_tick,
  .halt_req, .busy, .done, .result_data, .acc, .pc, .stack_top, .zero_flag, .carry_flag, .half_carry_flag,
  .overflow_flag, .watchdog_count, .timeout_flag, .powerdown_flag, .preclear_first_seen, .preclear_second_seen);
`default_nettype wire

// file: testbench.sv
/*
  Self-checking bench for lcc_exec: operation calls with expected values.
  Assumes the bench drives every input on the falling edge of a 4 ns clock.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench
  import lcc_pkg::*;
;
  // stimulus
  logic                 ref_clk = 1'b0, nrst = 1'b0, op_valid = 1'b0, load_wr_en = 1'b0;
  logic                 wdt_tick = 1'b0, halt_req = 1'b0;
  logic [OP_W-1:0]      op_code = 4'h0;
  logic [ADDR_W-1:0]    op_addr = 7'h00, load_addr = 7'h00;
  logic [DATA_W-1:0]    op_imm = 8'h00, load_data = 8'h00;
  logic [BIT_SEL_W-1:0] op_bit = 3'h0;
  logic [PC_W-1:0]      op_target = 11'h000;
  // observed outputs
  logic                 busy, done, zero_flag, carry_flag, half_carry_flag, overflow_flag;
  logic                 timeout_flag, powerdown_flag, preclear_first_seen, preclear_second_seen;
  logic [DATA_W-1:0]    result_data, acc, rd;
  logic [WDT_W-1:0]     watchdog_count;
  logic [PC_W-1:0]      pc, stack_top, old_pc;
  logic [8:0]           dref;
  logic                 cy = 1'b0;
  logic [7:0]           daa_in [5] = '{8'h45, 8'h4B, 8'h9A, 8'h12, 8'h99};
  int                   err_count = 0, samples_checked = 0;

  always #2 ref_clk = ~ref_clk;

  lcc_exec uut (.ref_clk, .nrst, .op_valid, .op_code, .op_addr, .op_imm, .op_bit, .op_target, .load_wr_en,
    .load_addr, .load_data, .wdt_tick, .halt_req, .busy, .done, .result_data, .acc, .pc, .stack_top,
    .zero_flag, .carry_flag, .half_carry_flag, .overflow_flag, .watchdog_count, .timeout_flag,
    .powerdown_flag, .preclear_first_seen, .preclear_second_seen);

  // verdict and end of run
  task wrap_up;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up

  // compare tasks, one per result kind
  task chk_addr(input logic [10:0] g, input logic [10:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask : chk_addr
  task chk_byte(input logic [7:0] g, input logic [7:0] e); chk_addr({3'h0, g}, {3'h0, e}); endtask : chk_byte
  task chk_flag(input logic g, input logic e); chk_addr({10'h000, g}, {10'h000, e}); endtask : chk_flag

  // one operation, from a falling edge to the done cycle
  task run_op(input logic [3:0] c, input logic [6:0] a = 7'h00, input logic [7:0] v = 8'h00,
              input logic [2:0] b = 3'h0, input logic [10:0] t = 11'h000);
    int n;
    n = 0;
    op_code = c; op_addr = a; op_imm = v; op_bit = b; op_target = t; op_valid = 1'b1;
    @(negedge ref_clk);
    op_valid = 1'b0;
    while (done !== 1'b1 && n < 8) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 8) begin
      err_count++;
      wrap_up;
    end
  endtask : run_op

  // preload, readback and accumulator setup
  task load(input logic [6:0] a, input logic [7:0] d);
    load_addr = a; load_data = d; load_wr_en = 1'b1;
    @(negedge ref_clk);
    load_wr_en = 1'b0;
  endtask : load
  task peek(input logic [6:0] a, output logic [7:0] d); run_op(LCC_OP_COMPLEMENT_TO_ACCUMULATOR_OP, a); d = ~acc; endtask : peek
  task set_acc(input logic [7:0] v); load(7'h5F, ~v); run_op(LCC_OP_COMPLEMENT_TO_ACCUMULATOR_OP, 7'h5F); endtask : set_acc
  task tick(input int n); wdt_tick = 1'b1; repeat (n) @(negedge ref_clk); wdt_tick = 1'b0; endtask : tick

  // decimal adjust reference, half carry never set by this unit
  function automatic logic [8:0] daa_ref(input logic [7:0] a, input logic c);
    logic [4:0] lo, hi;
    logic       ac1;
    lo = {1'b0, a[3:0]};
    ac1 = 1'b0;
    if (lo > 5'h09) begin
      lo = lo + 5'h06;
      ac1 = 1'b1;
    end
    hi = {1'b0, a[7:4]} + {4'h0, ac1};
    if (hi > 5'h09 || c) begin
      hi = hi + 5'h06;
      c = 1'b1;
    end
    return {c, hi[3:0], lo[3:0]};
  endfunction : daa_ref

  // main sequence
  initial begin
    repeat (8) @(negedge ref_clk);
    nrst = 1'b1;
    chk_addr(pc, 11'h000);
    set_acc(8'hF0); load(7'h01, 8'h3C); run_op(LCC_OP_AND_MEM, 7'h01);
    chk_byte(acc, 8'h30); chk_byte(result_data, 8'h30);
    chk_flag(zero_flag, 1'b0);
    run_op(LCC_OP_AND_IMM, 7'h00, 8'h0F); chk_byte(acc, 8'h00);
    chk_flag(zero_flag, 1'b1);
    set_acc(8'h0F); load(7'h02, 8'hA5); run_op(LCC_OP_AND_INTO_MEM, 7'h02);
    chk_byte(acc, 8'h0F); peek(7'h02, rd);
    chk_byte(rd, 8'h05);
    old_pc = pc; run_op(LCC_OP_CALL, 7'h00, 8'h00, 3'h0, 11'h123);
    chk_addr(pc, 11'h123);
    chk_addr(stack_top, old_pc + 11'h001);
    load(7'h03, 8'hFF); run_op(LCC_OP_CLR_BYTE, 7'h03); peek(7'h03, rd);
    chk_byte(rd, 8'h00);
    for (int i = 0; i < 8; i++) begin
      load(7'h04, 8'hFF); run_op(LCC_OP_CLR_BIT, 7'h04, 8'h00, i[2:0]); peek(7'h04, rd);
      chk_byte(rd, ~(8'h01 << i));
    end
    load(7'h05, 8'h5A); run_op(LCC_OP_CPL, 7'h05); peek(7'h05, rd);
    chk_byte(rd, 8'hA5);
    run_op(LCC_OP_COMPLEMENT_TO_ACCUMULATOR_OP, 7'h05); chk_byte(acc, 8'h5A);
    peek(7'h05, rd); chk_byte(rd, 8'hA5);
    load(7'h06, 8'h00); run_op(LCC_OP_DEC, 7'h06); peek(7'h06, rd);
    chk_byte(rd, 8'hFF);
    load(7'h07, 8'h01); run_op(LCC_OP_DECREMENT_TO_ACCUMULATOR_OP, 7'h07); chk_byte(acc, 8'h00);
    peek(7'h07, rd); chk_byte(rd, 8'h01);
    // carry chains from one adjust to the next
    for (int k = 0; k < 5; k++) begin
      set_acc(daa_in[k]); run_op(LCC_OP_DAA, 7'h08);
      dref = daa_ref(daa_in[k], cy); cy = dref[8];
      chk_byte(acc, daa_in[k]);
      chk_flag(carry_flag, cy);
      peek(7'h08, rd); chk_byte(rd, dref[7:0]);
    end
    // watchdog: powerdown, wrap to timeout, then preclears
    halt_req = 1'b1; @(negedge ref_clk); halt_req = 1'b0;
    tick(261); run_op(LCC_OP_WDT_PRE1);
    chk_byte(watchdog_count, 8'h05); chk_flag(preclear_first_seen, 1'b1);
    chk_flag(timeout_flag, 1'b1);
    chk_flag(powerdown_flag, 1'b1);
    run_op(LCC_OP_AND_IMM, 7'h00, 8'hFF); chk_flag(carry_flag, 1'b1);
    run_op(LCC_OP_WDT_PRE2); chk_flag(preclear_first_seen, 1'b0);
    chk_byte(watchdog_count, 8'h00);
    chk_flag(timeout_flag, 1'b0);
    chk_flag(powerdown_flag, 1'b0);
    run_op(LCC_OP_WDT_CLR); halt_req = 1'b1; @(negedge ref_clk); halt_req = 1'b0;
    tick(3); run_op(LCC_OP_WDT_PRE2);
    chk_byte(watchdog_count, 8'h03);
    chk_flag(powerdown_flag, 1'b1);
    chk_flag(preclear_second_seen, 1'b1);
    tick(254); chk_flag(timeout_flag, 1'b1);
    run_op(LCC_OP_WDT_CLR); chk_byte(watchdog_count, 8'h00);
    chk_flag(powerdown_flag, 1'b0); chk_flag(timeout_flag, 1'b0);
    wrap_up;
  end
endmodule : testbench
`default_nettype wire
